/* File: pkg/sfpe_pkg.sv */
package sfpe_pkg;

	// ***********************************************************
	// Timing
	// ***********************************************************
	localparam int CLK_PERIOD_NS      = 10;
	// Nominal durations of the self-timed cycles
	localparam int PAGE_WRITE_TIME_NS = 500000;
	localparam int WIPE_TIME_NS       = 45000000;
	localparam int PAGE_WRITE_CYCLES  = PAGE_WRITE_TIME_NS / CLK_PERIOD_NS;
	localparam int WIPE_CYCLES        = WIPE_TIME_NS / CLK_PERIOD_NS;

	// ***********************************************************
	// Opcodes
	// ***********************************************************
	localparam logic [7:0] OPC_ARM_WRITE       = 8'h06;
	localparam logic [7:0] OPC_DISARM_WRITE    = 8'h04;
	localparam logic [7:0] OPC_PAGE_WRITE      = 8'h02;
	localparam logic [7:0] OPC_QUAD_PAGE_WRITE = 8'h32;
	localparam logic [7:0] OPC_SMALL_WIPE      = 8'h20;
	localparam logic [7:0] OPC_BLOCK_WIPE_32K  = 8'h52;
	localparam logic [7:0] OPC_BLOCK_WIPE_64K  = 8'hD8;

	// ***********************************************************
	// Memory geometry
	// ***********************************************************
	localparam int          ADDR_W         = 24;
	localparam int          PAGE_BYTES     = 256;
	localparam int          PROT_W         = 5;
	localparam int          FIFO_DEPTH     = 8;
	localparam logic [7:0]  NUM_BLOCKS_64K = 8'h40;
	localparam logic [23:0] SECTOR_MASK    = 24'hFFF000;
	localparam logic [23:0] BLOCK32_MASK   = 24'hFF8000;
	localparam logic [23:0] BLOCK64_MASK   = 24'hFF0000;

	typedef enum logic [1:0] {
		OP_BYTE,
		OP_WIPE_4K,
		OP_WIPE_32K,
		OP_WIPE_64K
	} sfpe_op_t;

	// One job for the memory array behind the sequencer
	typedef struct packed {
		sfpe_op_t    op;
		logic [23:0] addr;
		logic [7:0]  data;
	} sfpe_mem_word_t;

endpackage

/* File: rtl/sfpe_fifo.sv */
`timescale 1ns/1ps
module sfpe_fifo #(
	parameter int WIDTH = 34,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready
);
	import sfpe_pkg::*;

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wr_ptr;
		logic [PW-1:0]               rd_ptr;
		logic [CW-1:0]               count;
	} sfpe_fifo_state_t;

	sfpe_fifo_state_t st;
	sfpe_fifo_state_t next_st;
	logic             push;
	logic             pop;

	assign in_ready  = (st.count != CW'(DEPTH));
	assign out_valid = (st.count != '0);
	assign out_data  = st.mem[st.rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		next_st = st;
		if (push) begin
			next_st.mem[st.wr_ptr] = in_data;
			next_st.wr_ptr = (st.wr_ptr == PW'(DEPTH - 1)) ? '0 : st.wr_ptr + PW'(1);
		end
		if (pop) begin
			next_st.rd_ptr = (st.rd_ptr == PW'(DEPTH - 1)) ? '0 : st.rd_ptr + PW'(1);
		end
		if (push && !pop) begin
			next_st.count = st.count + CW'(1);
		end else if (pop && !push) begin
			next_st.count = st.count - CW'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

endmodule // sfpe_fifo

/* File: rtl/sfpe_core.sv */
`timescale 1ns/1ps
module sfpe_core #(
	parameter int PAGE_CYCLES = sfpe_pkg::PAGE_WRITE_CYCLES,
	parameter int WIPE_CYCLES = sfpe_pkg::WIPE_CYCLES
) (
	input  wire logic                  CORE_CLK,
	input  wire logic                  RST_N,
	input  wire logic                  CS_N,
	input  wire logic                  SCLK,
	input  wire logic [3:0]            QUAD_DATA_LANES,
	input  wire logic                  QUAD_LANE_ENABLE,
	input  wire logic [4:0]            PROTECTION_LEVEL_BITS,
	output logic                       WRITE_LATCH_FLAG,
	output logic                       OPERATION_IN_PROGRESS,
	output logic                       MEM_VALID,
	output sfpe_pkg::sfpe_mem_word_t   MEM_WORD,
	input  wire logic                  MEM_READY
);
	import sfpe_pkg::*;

	// ***********************************************************
	// State
	// ***********************************************************
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CMD,
		ST_ADDR,
		ST_DATA,
		ST_ADDR_DONE,
		ST_IGNORE
	} sfpe_phase_t;

	typedef struct packed {
		logic                             cs_s1;
		logic                             cs_s2;
		logic                             cs_prev;
		logic                             ck_s1;
		logic                             ck_s2;
		logic                             ck_prev;
		logic [3:0]                       io_s1;
		logic [3:0]                       io_s2;
		sfpe_phase_t                      phase;
		logic                             quad;
		logic [2:0]                       bitcnt;
		logic [7:0]                       shreg;
		logic [7:0]                       opcode;
		logic [1:0]                       addr_bytes;
		logic [23:0]                      addr;
		logic [7:0]                       ptr;
		logic                             have_data;
		logic [PAGE_BYTES-1:0]            mask;
		logic [PAGE_BYTES-1:0][7:0]       buffer;
		logic                             latch;
		logic                             busy;
		logic [31:0]                      timer;
		logic                             draining;
		sfpe_op_t                         cur_op;
		logic [7:0]                       scan;
	} sfpe_state_t;

	sfpe_state_t    st;
	sfpe_state_t    next_st;
	logic           cs_fall;
	logic           cs_rise;
	logic           ck_rise;
	logic           prot_now;
	logic           is_page;
	logic           fifo_in_valid;
	logic           fifo_in_ready;
	sfpe_mem_word_t fifo_in_word;

	// True when the address lies in the top lvl 64KB blocks; level 0 protects none
	function automatic logic prot_hit(input logic [23:0] a, input logic [4:0] lvl);
		logic [7:0] first;
		first = NUM_BLOCKS_64K - {3'h0, lvl};
		return (lvl != 5'h0) && (a[23:16] >= first);
	endfunction

	// Edges are judged on the second sync stage only
	assign cs_fall  = st.cs_prev && !st.cs_s2;
	assign cs_rise  = !st.cs_prev && st.cs_s2;
	assign ck_rise  = !st.ck_prev && st.ck_s2 && !st.cs_s2;
	assign prot_now = prot_hit(st.addr, PROTECTION_LEVEL_BITS);
	assign is_page  = (st.opcode == OPC_PAGE_WRITE) || (st.opcode == OPC_QUAD_PAGE_WRITE);

	assign WRITE_LATCH_FLAG      = st.latch;
	assign OPERATION_IN_PROGRESS = st.busy;

	// ***********************************************************
	// Next state
	// ***********************************************************
	always_comb begin
		logic       quad_now;
		logic [7:0] byte_in;
		logic [2:0] bits_in;
		quad_now      = 1'b0;
		byte_in       = 8'h00;
		bits_in       = 3'h0;
		next_st       = st;
		fifo_in_valid = 1'b0;
		fifo_in_word  = '0;

		next_st.cs_s1   = CS_N;
		next_st.cs_s2   = st.cs_s1;
		next_st.cs_prev = st.cs_s2;
		next_st.ck_s1   = SCLK;
		next_st.ck_s2   = st.ck_s1;
		next_st.ck_prev = st.ck_s2;
		next_st.io_s1   = QUAD_DATA_LANES;
		next_st.io_s2   = st.io_s1;

		if (st.busy) begin
			if (st.timer != 32'h0) begin
				next_st.timer = st.timer - 32'h1;
			end else if (!st.draining) begin
				next_st.busy = 1'b0;
			end
		end

		// Draining stalls on the FIFO, so a slow array stretches the busy time
		if (st.draining) begin
			fifo_in_word.op = st.cur_op;
			unique case (st.cur_op)
				OP_BYTE: begin
					fifo_in_valid     = st.mask[st.scan];
					fifo_in_word.addr = {st.addr[23:8], st.scan};
					fifo_in_word.data = st.buffer[st.scan];
					if (!st.mask[st.scan] || fifo_in_ready) begin
						next_st.scan = st.scan + 8'h01;
						if (st.scan == 8'hFF) begin
							next_st.draining = 1'b0;
						end
					end
				end
				OP_WIPE_4K, OP_WIPE_32K, OP_WIPE_64K: begin
					fifo_in_valid     = 1'b1;
					fifo_in_word.addr = st.addr & ((st.cur_op == OP_WIPE_4K) ? SECTOR_MASK :
						(st.cur_op == OP_WIPE_32K) ? BLOCK32_MASK : BLOCK64_MASK);
					if (fifo_in_ready) begin
						next_st.draining = 1'b0;
					end
				end
			endcase
		end

		if (cs_fall) begin
			next_st.bitcnt     = 3'h0;
			next_st.addr_bytes = 2'h0;
			next_st.have_data  = 1'b0;
			next_st.quad       = 1'b0;
			// Commands are refused outright while a cycle runs
			next_st.phase = st.busy ? ST_IGNORE : ST_CMD;
			if (!st.busy) begin
				next_st.mask = '0;
			end
		end else if (cs_rise) begin
			next_st.phase = ST_IDLE;
			if (!st.busy) begin
				unique case (st.phase)
					ST_ADDR_DONE: begin
						if (st.opcode == OPC_ARM_WRITE) begin
							next_st.latch = 1'b1;
						end else if (st.opcode == OPC_DISARM_WRITE) begin
							next_st.latch = 1'b0;
						end else if (st.latch && !prot_now) begin
							next_st.busy     = 1'b1;
							next_st.latch    = 1'b0;
							next_st.draining = 1'b1;
							next_st.timer = 32'(WIPE_CYCLES - 1);
							next_st.cur_op = (st.opcode == OPC_SMALL_WIPE) ? OP_WIPE_4K :
								(st.opcode == OPC_BLOCK_WIPE_32K) ? OP_WIPE_32K : OP_WIPE_64K;
						end
					end
					ST_DATA: begin
						if (st.bitcnt == 3'h0 && st.have_data && st.latch && !prot_now) begin
							next_st.busy     = 1'b1;
							next_st.latch    = 1'b0;
							next_st.draining = 1'b1;
							next_st.scan     = 8'h00;
							next_st.cur_op   = OP_BYTE;
							next_st.timer    = 32'(PAGE_CYCLES - 1);
						end
					end
					ST_IDLE, ST_CMD, ST_ADDR, ST_IGNORE: begin
						next_st.phase = ST_IDLE;
					end
				endcase
			end
		end else if (ck_rise) begin
			quad_now = st.quad && (st.phase != ST_CMD);
			byte_in  = quad_now ? {st.shreg[3:0], st.io_s2} : {st.shreg[6:0], st.io_s2[0]};
			bits_in  = st.bitcnt + (quad_now ? 3'h4 : 3'h1);
			if (st.phase == ST_ADDR_DONE) begin
				next_st.phase = ST_IGNORE;
			end else if (st.phase inside {ST_CMD, ST_ADDR, ST_DATA}) begin
				next_st.shreg  = byte_in;
				next_st.bitcnt = bits_in;
			end
			if (bits_in == 3'h0) begin
				unique case (st.phase)
					ST_CMD: begin
						next_st.opcode = byte_in;
						unique case (byte_in)
							OPC_ARM_WRITE, OPC_DISARM_WRITE: begin
								next_st.phase = ST_ADDR_DONE;
							end
							OPC_PAGE_WRITE, OPC_SMALL_WIPE, OPC_BLOCK_WIPE_32K,
							OPC_BLOCK_WIPE_64K: begin
								next_st.phase = ST_ADDR;
							end
							OPC_QUAD_PAGE_WRITE: begin
								next_st.quad  = QUAD_LANE_ENABLE;
								next_st.phase = QUAD_LANE_ENABLE ? ST_ADDR : ST_IGNORE;
							end
							default: begin
								next_st.phase = ST_IGNORE;
							end
						endcase
					end
					ST_ADDR: begin
						next_st.addr       = {st.addr[15:0], byte_in};
						next_st.addr_bytes = st.addr_bytes + 2'h1;
						if (st.addr_bytes == 2'h2) begin
							next_st.phase = is_page ? ST_DATA : ST_ADDR_DONE;
							next_st.ptr   = byte_in;
						end
					end
					ST_DATA: begin
						next_st.buffer[st.ptr] = byte_in;
						next_st.mask[st.ptr]   = 1'b1;
						next_st.ptr            = st.ptr + 8'h01;
						next_st.have_data      = 1'b1;
					end
					ST_IDLE, ST_ADDR_DONE, ST_IGNORE: begin
						next_st.bitcnt = st.bitcnt;
					end
				endcase
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			st <= '0;
			// Select idles high, so its sync stages start high to avoid a false rise
			st.cs_s1   <= 1'b1;
			st.cs_s2   <= 1'b1;
			st.cs_prev <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// ***********************************************************
	// Job buffer toward the array
	// ***********************************************************
	sfpe_fifo #(
		.WIDTH ($bits(sfpe_mem_word_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (CORE_CLK),
		.rst_n     (RST_N),
		.in_valid  (fifo_in_valid),
		.in_data   (fifo_in_word),
		.in_ready  (fifo_in_ready),
		.out_valid (MEM_VALID),
		.out_data  (MEM_WORD),
		.out_ready (MEM_READY)
	);

	// ***********************************************************
	// Checks
	// ***********************************************************
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);

	chk_start_needs_latch: assert property (
		$rose(st.busy) |-> $past(st.latch) && $past(cs_rise))
		else $error("cycle started without armed write latch");

	chk_latch_cleared: assert property (
		$rose(st.busy) |-> !st.latch)
		else $error("write latch still set after cycle start");

	chk_midbyte_release: assert property (
		(cs_rise && !st.busy && st.phase == ST_DATA && st.bitcnt != 3'h0) |=> !st.busy)
		else $error("page write ran after mid-byte release");

	chk_protect_skip: assert property (
		(cs_rise && !st.busy && prot_now) |=> !st.busy)
		else $error("protected region was touched");

	chk_status_follows: assert property (
		(OPERATION_IN_PROGRESS && (st.timer != 32'h0 || st.draining)) |=> OPERATION_IN_PROGRESS)
		else $error("in-progress flag dropped while cycle still running");

	chk_byte_latched: assert property (
		(ck_rise && st.phase == ST_DATA && next_st.bitcnt == 3'h0 && !cs_rise)
		|=> st.mask[$past(st.ptr)] && st.ptr == $past(st.ptr) + 8'h01)
		else $error("data byte not latched at its page index");

	chk_addr_release: assert property (
		(cs_rise && !st.busy && st.phase == ST_ADDR) |=> !st.busy)
		else $error("wipe ran after early release");

	chk_wipe_timer: assert property (
		($rose(st.busy) && st.cur_op != OP_BYTE) |-> st.timer == 32'(WIPE_CYCLES - 1))
		else $error("wipe timer loaded wrong");

	cov_page_write: cover property ($rose(st.busy) && st.cur_op == OP_BYTE);
	cov_wipe: cover property ($rose(st.busy) && st.cur_op == OP_WIPE_64K);
	cov_no_latch: cover property (cs_rise && st.phase == ST_ADDR_DONE && !st.latch && !st.busy);
	cov_fifo_full: cover property (st.draining && !fifo_in_ready);

endmodule // sfpe_core

/* File: verification/sfpe_host.sv */
`timescale 1ns/1ps
module sfpe_host (
	input  logic       clk,
	output logic       cs_n,
	output logic       sclk,
	output logic [3:0] lanes
);
	import sfpe_pkg::*;
	logic [7:0] dat [300];

	initial begin
		cs_n  = 1'b1;
		sclk  = 1'b0;
		lanes = 4'h5;
	end

	// *****************************
	// Link driving
	// *****************************
	// Unread lanes toggle so a stale value is never mistaken for data
	task automatic put(input logic [7:0] b, input int nb, input bit q);
		for (int i = 7; i > 7 - nb; i -= (q ? 4 : 1)) begin
			lanes = q ? b[i -: 4] : {~lanes[3:1], b[i]};
			#80 sclk = 1'b1;
			#80 sclk = 1'b0;
		end
	endtask

	task automatic frame(input logic [7:0] op, input logic [23:0] a, input int na,
			input int nd, input bit q, input int xb);
		// Start on a falling core edge; all later steps are multiples of 80 ns
		@(negedge clk);
		cs_n = 1'b0;
		#80 put(op, 8, 1'b0);
		for (int k = 0; k < na; k++)
			put(a[23 - 8 * k -: 8], 8, q);
		for (int k = 0; k < nd; k++)
			put(dat[k], 8, q);
		if (xb > 0)
			put(8'hA5, xb, 1'b0);
		#80 cs_n = 1'b1;
		lanes = ~lanes;
	endtask

	task automatic arm();
		frame(OPC_ARM_WRITE, 24'h000000, 0, 0, 1'b0, 0);
	endtask
endmodule // sfpe_host

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import sfpe_pkg::*;
	localparam int PC = 20;
	localparam int WC = 40;

	logic           core_clk  = 1'b0;
	logic           rst_n     = 1'b0;
	logic           qe        = 1'b0;
	logic [4:0]     prot      = 5'h00;
	logic           mem_ready = 1'b0;
	logic           cs_n;
	logic           sclk;
	logic [3:0]     lanes;
	logic           latch;
	logic           busy;
	logic           mem_valid;
	sfpe_mem_word_t mem_word;
	sfpe_mem_word_t jobs [$];
	logic [15:0]    rr        = 16'hDC5B;
	logic [15:0]    sd        = 16'hDC5B;
	int             err_count = 0;
	int             comparisons = 0;
	int             cycles    = 0;

	always #5 core_clk = ~core_clk;

	sfpe_host host (.clk(core_clk), .cs_n(cs_n), .sclk(sclk), .lanes(lanes));

	sfpe_core #(.PAGE_CYCLES(PC), .WIPE_CYCLES(WC)) DUT (
		.CORE_CLK(core_clk),
		.RST_N(rst_n),
		.CS_N(cs_n),
		.SCLK(sclk),
		.QUAD_DATA_LANES(lanes),
		.QUAD_LANE_ENABLE(qe),
		.PROTECTION_LEVEL_BITS(prot),
		.WRITE_LATCH_FLAG(latch),
		.OPERATION_IN_PROGRESS(busy),
		.MEM_VALID(mem_valid),
		.MEM_WORD(mem_word),
		.MEM_READY(mem_ready)
	);

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Latest data byte landing on page slot idx, -1 if none
	function automatic int src(input int idx, input int lo, input int nd);
		for (int i = nd - 1; i >= 0; i--)
			if ((lo + i) % 256 == idx)
				return i;
		return -1;
	endfunction

	// Memory side stalls at random
	always @(posedge core_clk)
		if (mem_valid === 1'b1 && mem_ready)
			jobs.push_back(mem_word);
	always @(negedge core_clk) begin
		rr <= lfsr(rr);
		mem_ready <= rr[0] | rr[1];
	end

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 60000) begin
			err_count++;
			give_verdict();
		end
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string m);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic arm();
		host.arm();
		repeat (12) @(posedge core_clk);
		check(latch, 1'b1, "latch not set");
	endtask

	// minlen 0 means the command must be refused
	task automatic run(input logic [7:0] op, input logic [23:0] a, input int nd,
			input bit q, input int xb, input int minlen);
		int len;
		len = 0;
		jobs.delete();
		host.frame(op, a, 3, nd, q, xb);
		for (int i = 0; i < 12 && busy !== 1'b1; i++)
			@(posedge core_clk);
		if (busy === 1'b1)
			check(latch, 1'b0, "latch kept in cycle");
		while (busy === 1'b1 && len < 9000) begin
			@(posedge core_clk);
			len++;
		end
		check(minlen == 0 ? len == 0 : len >= minlen, 1'b1, "busy length");
		for (int i = 0; i < 100 && mem_valid === 1'b1; i++)
			@(posedge core_clk);
		if (minlen == 0)
			check(jobs.size(), 0, "job from refused command");
		$display("test done op %h addr %h", op, a);
	endtask

	task automatic page(input logic [23:0] a, input int nd, input bit q);
		int k;
		int s;
		k = 0;
		arm();
		for (int i = 0; i < nd; i++) begin
			sd = lfsr(sd);
			host.dat[i] = sd[7:0];
		end
		run(q ? OPC_QUAD_PAGE_WRITE : OPC_PAGE_WRITE, a, nd, q, 0, PC);
		for (int i = 0; i < 256; i++) begin
			s = src(i, a[7:0], nd);
			if (s >= 0) begin
				check(jobs[k], {OP_BYTE, a[23:8], i[7:0], host.dat[s]}, "byte job");
				k++;
			end
		end
		check(jobs.size(), k, "job count");
	endtask

	task automatic wipe(input logic [7:0] op, input sfpe_op_t t, input logic [23:0] m,
			input logic [23:0] a);
		arm();
		run(op, a, 0, 1'b0, 0, WC);
		check(jobs.size(), 1, "wipe job count");
		check(jobs[0], {t, a & m, 8'h00}, "wipe job");
	endtask

	initial begin
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		rst_n = 1'b1;
		repeat (6) @(posedge core_clk);
		check({busy, latch}, 2'b00, "reset state");
		arm();
		host.frame(OPC_DISARM_WRITE, 24'h000000, 0, 0, 1'b0, 0);
		repeat (12) @(posedge core_clk);
		check(latch, 1'b0, "latch kept after disarm");
		run(OPC_PAGE_WRITE, 24'h001000, 1, 1'b0, 0, 0);
		page(24'h0012FE, 4, 1'b0);
		arm();
		run(OPC_PAGE_WRITE, 24'h000100, 2, 1'b0, 3, 0);
		arm();
		run(OPC_QUAD_PAGE_WRITE, 24'h000300, 1, 1'b1, 0, 0);
		@(negedge core_clk);
		qe = 1'b1;
		page({16'h0002, sd[7:0]}, 258, 1'b1);
		wipe(OPC_SMALL_WIPE, OP_WIPE_4K, SECTOR_MASK, 24'h012345);
		wipe(OPC_BLOCK_WIPE_32K, OP_WIPE_32K, BLOCK32_MASK, 24'h02ABCD);
		wipe(OPC_BLOCK_WIPE_64K, OP_WIPE_64K, BLOCK64_MASK, 24'h03FFFF);
		arm();
		run(OPC_SMALL_WIPE, 24'h005000, 0, 1'b0, 1, 0);
		@(negedge core_clk);
		prot = 5'h01;
		arm();
		run(OPC_PAGE_WRITE, 24'h3F0010, 1, 1'b0, 0, 0);
		arm();
		run(OPC_BLOCK_WIPE_64K, 24'h3F8000, 0, 1'b0, 0, 0);
		give_verdict();
	end
endmodule // tb_top
